// ---- lmsc_pkg.sv ----
/*
 * Constants, types and register map of the load model select block.
 * Assumes one 100 MHz clock, an active-low asynchronous reset and a
 * plain strobe register port driven from the same clock domain.
 */
// Behaviour
// - bit 7 picks current or power model
// - bits 2:0 pick load source, default 1
// - current, source 0: last run average
// - current, source 1: present run average
// - current, 2 averaged, 3 filtered 14 s
// - current, source 4: capacity over five
// - current, 6 user rate; 5,7 reserved
// - power, source 0: last run average
// - power, source 1: present run average
// - power, 2/3 current times voltage
// - power, 4 energy/5, 6 user rate
// - status bit mirrors active model
// - capacity 16 bit, 0..8000, default 1340
// - energy 16 bit, 0..32767, default 4960
// - terminate voltage 2500..3700, default 3200
// - learn delta; empty at terminate plus delta
// - present average only after 500 s
`default_nettype none
package lmsc_pkg;
	// Register offsets
	localparam logic [7:0] OFS_LOAD_CFG = 8'h05;
	localparam logic [7:0] OFS_DESIGN_CAP = 8'h06;
	localparam logic [7:0] OFS_DESIGN_NRG = 8'h08;
	localparam logic [7:0] OFS_TERM_V = 8'h0A;
	localparam logic [7:0] OFS_USER_MA = 8'h0C;
	localparam logic [7:0] OFS_USER_MW = 8'h0E;
	localparam logic [7:0] OFS_AVG_I_LAST = 8'h19;
	localparam logic [7:0] OFS_AVG_P_LAST = 8'h1B;
	localparam logic [7:0] OFS_DELTA_V = 8'h1D;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_LOAD_LO = 8'h22;
	localparam logic [7:0] OFS_LOAD_HI = 8'h23;
	localparam logic [7:0] OFS_EOD_V = 8'h24;
	// Reset values
	localparam logic [7:0] RST_LOAD_CFG = 8'h81;
	localparam logic [15:0] RST_DESIGN_CAP = 16'h053C;
	localparam logic [15:0] RST_DESIGN_NRG = 16'h1360;
	localparam logic [15:0] RST_TERM_V = 16'h0C80;
	localparam logic [15:0] RST_USER_MA = 16'h0000;
	localparam logic [15:0] RST_USER_MW = 16'h0000;
	localparam logic [15:0] RST_AVG_LAST = 16'hFFCE;
	localparam logic [15:0] RST_DELTA_V = 16'h0001;
	// Value ranges
	localparam logic [15:0] MAX_DESIGN_CAP = 16'h1F40;
	localparam logic [15:0] MAX_DESIGN_NRG = 16'h7FFF;
	localparam logic [15:0] MIN_TERM_V = 16'h09C4;
	localparam logic [15:0] MAX_TERM_V = 16'h0E74;
	localparam logic [15:0] MAX_DELTA_V = 16'h03E8;
	// Load source encodings
	localparam logic [2:0] SEL_LAST_RUN = 3'h0;
	localparam logic [2:0] SEL_PRESENT_RUN = 3'h1;
	localparam logic [2:0] SEL_AVERAGED = 3'h2;
	localparam logic [2:0] SEL_FILTERED = 3'h3;
	localparam logic [2:0] SEL_DESIGN_DIV5 = 3'h4;
	localparam logic [2:0] SEL_RSVD_A = 3'h5;
	localparam logic [2:0] SEL_USER_RATE = 3'h6;
	localparam logic [2:0] SEL_RSVD_B = 3'h7;
	localparam logic [2:0] RST_SEL = 3'h1;
	// Status word bit positions
	localparam int ST_MODE_BIT = 0;
	localparam int ST_LONG_BIT = 1;
	localparam int ST_EMPTY_BIT = 2;
	// Arithmetic constants
	localparam int DESIGN_DIVISOR = 5;
	localparam int MILLI_SCALE = 1000;
	localparam int LPF_FRAC = 8;
	// Timing
	localparam int CLK_HZ = 100_000_000;
	localparam int SEC_PER_TICK = 1;
	localparam int SEC_CYCLES = CLK_HZ * SEC_PER_TICK;
	localparam int SETTLE_S = 500;
	localparam int LPF_TAU_S = 14;
	localparam logic [15:0] SETTLE_TICKS = 16'(SETTLE_S / SEC_PER_TICK);
	localparam int LPF_TAU_TICKS = LPF_TAU_S / SEC_PER_TICK;
	// Load configuration byte
	typedef struct packed {
		logic power_mode;
		logic [3:0] rsvd;
		logic [2:0] sel;
	} lmsc_cfg_t;
	// Measurement inputs
	typedef struct packed {
		logic signed [15:0] current_ma;
		logic [15:0] voltage_mv;
	} lmsc_meas_t;
	// Discharge run tracker
	typedef enum logic [1:0] {
		RUN_IDLE = 2'b00,
		RUN_EARLY = 2'b01,
		RUN_LONG = 2'b11
	} lmsc_run_t;
endpackage : lmsc_pkg
`default_nettype wire

// ---- lmsc_lpf.sv ----
/*
 * First-order low-pass filter on the averaged current, stepped once per tick.
 * Assumes the tick is a one-cycle pulse from the same clock domain.
 */
`default_nettype none
module lmsc_lpf (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic tick_i,
	input wire logic signed [15:0] x_i,
	output logic signed [31:0] y_o
);
	logic signed [31:0] acc_reg;
	logic signed [31:0] acc_next;
	logic signed [31:0] x_scaled;

	// Extra fraction bits keep small steps from vanishing
	always_comb begin
		x_scaled = 32'(x_i) <<< lmsc_pkg::LPF_FRAC;
		acc_next = acc_reg + (x_scaled - acc_reg) / lmsc_pkg::LPF_TAU_TICKS;
	end

	// Step per tick
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			acc_reg <= 32'h00000000;
		end else if (tick_i) begin
			acc_reg <= acc_next;
		end
	end

	// Drop fraction bits
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			y_o <= 32'h00000000;
		end else begin
			y_o <= acc_reg >>> lmsc_pkg::LPF_FRAC;
		end
	end
endmodule : lmsc_lpf
`default_nettype wire

// ---- lmsc_top.sv ----
/*
 * Load model configuration registers and load source selection.
 * Assumes measurement inputs and the discharge flag come from logic on
 * SYS_CLK_I, and a register master that never issues two strobes at once.
 */
// Local design decision: the address-and-strobe port.
`default_nettype none
module lmsc_top #(
	parameter int SEC_CYCLES = lmsc_pkg::SEC_CYCLES
) (
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire lmsc_pkg::lmsc_meas_t MEAS_I,
	input wire logic DSG_ACTIVE_I,
	input wire logic SPIKE_VALID_I,
	input wire logic [15:0] SPIKE_MV_I,
	output logic [15:0] RDATA_O,
	output logic signed [31:0] LOAD_VALUE_O,
	output logic LOAD_MODE_O,
	output logic [15:0] DESIGN_CAP_O,
	output logic [15:0] DESIGN_NRG_O,
	output logic [15:0] EOD_VOLTAGE_O,
	output logic CHARGE_EMPTY_O
);
	lmsc_pkg::lmsc_cfg_t cfg_reg;
	logic [15:0] design_cap_reg;
	logic [15:0] design_nrg_reg;
	logic [15:0] term_v_reg;
	logic [15:0] user_ma_reg;
	logic [15:0] user_mw_reg;
	logic [15:0] avg_i_last_reg;
	logic [15:0] avg_p_last_reg;
	logic [15:0] delta_v_reg;
	logic active_mode_reg;
	logic [2:0] active_sel_reg;
	lmsc_pkg::lmsc_run_t run_reg;
	lmsc_pkg::lmsc_run_t run_next;
	logic [31:0] sec_cnt_reg;
	logic tick_reg;
	logic [15:0] run_secs_reg;
	logic signed [47:0] sum_i_reg;
	logic signed [47:0] sum_p_reg;
	logic signed [31:0] run_avg_i;
	logic signed [31:0] run_avg_p;
	logic signed [31:0] inst_p;
	logic signed [31:0] filt_i;
	logic signed [31:0] filt_p;
	logic signed [31:0] load_next;
	logic dsg_d_reg;
	logic [15:0] eod_next;
	logic wr_cfg;
	logic cfg_valid;

	// Saturating narrow to a signed 16-bit field
	function automatic logic [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sh00007FFF) begin
			sat16 = 16'h7FFF;
		end else if (v < -32'sh00008000) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction : sat16

	// Mean of a running sum; zero count gives zero
	function automatic logic signed [31:0] run_mean(input logic signed [47:0] s, input logic [15:0] n);
		logic signed [47:0] q;
		q = 48'sh0;
		if (n != 16'h0000) begin
			q = s / $signed({32'h00000000, n});
		end
		run_mean = q[31:0];
	endfunction : run_mean

	// Current in mA times voltage in mV, scaled to mW
	function automatic logic signed [31:0] to_mw(input logic signed [31:0] i, input logic [15:0] v);
		logic signed [47:0] p;
		p = 48'(i) * $signed({32'h00000000, v});
		p = p / lmsc_pkg::MILLI_SCALE;
		to_mw = p[31:0];
	endfunction : to_mw

	// Clamp into an unsigned range
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		if (v < lo) begin
			clamp = lo;
		end else if (v > hi) begin
			clamp = hi;
		end else begin
			clamp = v;
		end
	endfunction : clamp

	assign wr_cfg = WR_I && (ADDR_I == lmsc_pkg::OFS_LOAD_CFG);
	// Reserved encodings never reach the decoder
	assign cfg_valid = (WDATA_I[2:0] != lmsc_pkg::SEL_RSVD_A) && (WDATA_I[2:0] != lmsc_pkg::SEL_RSVD_B);

	// Configuration byte keeps whatever was written
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cfg_reg <= lmsc_pkg::RST_LOAD_CFG;
		end else if (wr_cfg) begin
			cfg_reg <= WDATA_I[7:0];
		end
	end

	// Decoded model; bits 6:3 are left out of it on purpose
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			active_mode_reg <= lmsc_pkg::RST_LOAD_CFG[7];
			active_sel_reg <= lmsc_pkg::RST_SEL;
		end else if (wr_cfg) begin
			active_mode_reg <= WDATA_I[7];
			if (cfg_valid) begin
				active_sel_reg <= WDATA_I[2:0];
			end
		end
	end

	// Design parameters, clamped to their legal ranges
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			design_cap_reg <= lmsc_pkg::RST_DESIGN_CAP;
			design_nrg_reg <= lmsc_pkg::RST_DESIGN_NRG;
			term_v_reg <= lmsc_pkg::RST_TERM_V;
		end else if (WR_I) begin
			case (ADDR_I)
				lmsc_pkg::OFS_DESIGN_CAP: begin
					design_cap_reg <= clamp(WDATA_I, 16'h0000, lmsc_pkg::MAX_DESIGN_CAP);
				end
				lmsc_pkg::OFS_DESIGN_NRG: begin
					design_nrg_reg <= clamp(WDATA_I, 16'h0000, lmsc_pkg::MAX_DESIGN_NRG);
				end
				lmsc_pkg::OFS_TERM_V: begin
					term_v_reg <= clamp(WDATA_I, lmsc_pkg::MIN_TERM_V, lmsc_pkg::MAX_TERM_V);
				end
				default: begin
				end
			endcase
		end
	end

	// User rates
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			user_ma_reg <= lmsc_pkg::RST_USER_MA;
			user_mw_reg <= lmsc_pkg::RST_USER_MW;
		end else if (WR_I) begin
			if (ADDR_I == lmsc_pkg::OFS_USER_MA) begin
				user_ma_reg <= WDATA_I;
			end
			if (ADDR_I == lmsc_pkg::OFS_USER_MW) begin
				user_mw_reg <= WDATA_I;
			end
		end
	end

	// One-second tick; long count shortened by parameter in simulation
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sec_cnt_reg <= 32'h00000000;
			tick_reg <= 1'b0;
		end else if (sec_cnt_reg >= 32'(SEC_CYCLES - 1)) begin
			sec_cnt_reg <= 32'h00000000;
			tick_reg <= 1'b1;
		end else begin
			sec_cnt_reg <= sec_cnt_reg + 32'h00000001;
			tick_reg <= 1'b0;
		end
	end

	// Discharge run tracker
	always_comb begin
		run_next = run_reg;
		case (run_reg)
			lmsc_pkg::RUN_IDLE: begin
				if (DSG_ACTIVE_I) begin
					run_next = lmsc_pkg::RUN_EARLY;
				end
			end
			lmsc_pkg::RUN_EARLY: begin
				if (!DSG_ACTIVE_I) begin
					run_next = lmsc_pkg::RUN_IDLE;
				end else if (run_secs_reg >= lmsc_pkg::SETTLE_TICKS) begin
					run_next = lmsc_pkg::RUN_LONG;
				end
			end
			lmsc_pkg::RUN_LONG: begin
				if (!DSG_ACTIVE_I) begin
					run_next = lmsc_pkg::RUN_IDLE;
				end
			end
			default: begin
				run_next = lmsc_pkg::RUN_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			run_reg <= lmsc_pkg::RUN_IDLE;
			dsg_d_reg <= 1'b0;
		end else begin
			run_reg <= run_next;
			dsg_d_reg <= DSG_ACTIVE_I;
		end
	end

	// Running sums, restarted at each discharge start
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			run_secs_reg <= 16'h0000;
			sum_i_reg <= 48'sh0;
			sum_p_reg <= 48'sh0;
		end else if (DSG_ACTIVE_I && !dsg_d_reg) begin
			run_secs_reg <= 16'h0000;
			sum_i_reg <= 48'sh0;
			sum_p_reg <= 48'sh0;
		end else if (DSG_ACTIVE_I && tick_reg && run_secs_reg != 16'hFFFF) begin
			run_secs_reg <= run_secs_reg + 16'h0001;
			sum_i_reg <= sum_i_reg + 48'(MEAS_I.current_ma);
			sum_p_reg <= sum_p_reg + 48'(inst_p);
		end
	end

	assign run_avg_i = run_mean(sum_i_reg, run_secs_reg);
	assign run_avg_p = run_mean(sum_p_reg, run_secs_reg);
	assign inst_p = to_mw(32'(MEAS_I.current_ma), MEAS_I.voltage_mv);
	assign filt_p = to_mw(filt_i, MEAS_I.voltage_mv);

	// Last-run averages, stored when a long enough discharge ends
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			avg_i_last_reg <= lmsc_pkg::RST_AVG_LAST;
			avg_p_last_reg <= lmsc_pkg::RST_AVG_LAST;
		end else if (run_reg == lmsc_pkg::RUN_LONG && !DSG_ACTIVE_I) begin
			avg_i_last_reg <= sat16(run_avg_i);
			avg_p_last_reg <= sat16(run_avg_p);
		end else if (WR_I) begin
			if (ADDR_I == lmsc_pkg::OFS_AVG_I_LAST) begin
				avg_i_last_reg <= WDATA_I;
			end
			if (ADDR_I == lmsc_pkg::OFS_AVG_P_LAST) begin
				avg_p_last_reg <= WDATA_I;
			end
		end
	end

	// Filtered averaged current
	lmsc_lpf u_lpf (
		.clk_i(SYS_CLK_I),
		.resetn_i(RESETN_I),
		.tick_i(tick_reg),
		.x_i(MEAS_I.current_ma),
		.y_o(filt_i)
	);

	// Learned spike margin grows with larger spikes, up to its ceiling; a register write sets it directly unless a larger spike comes in the same cycle
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			delta_v_reg <= lmsc_pkg::RST_DELTA_V;
		end else if (SPIKE_VALID_I && SPIKE_MV_I > delta_v_reg) begin
			delta_v_reg <= clamp(SPIKE_MV_I, 16'h0000, lmsc_pkg::MAX_DELTA_V);
		end else if (WR_I && ADDR_I == lmsc_pkg::OFS_DELTA_V) begin
			delta_v_reg <= clamp(WDATA_I, 16'h0000, lmsc_pkg::MAX_DELTA_V);
		end
	end

	// Discharge sources are negative, so fixed rates are negated
	always_comb begin
		load_next = LOAD_VALUE_O;
		if (!active_mode_reg) begin
			case (active_sel_reg)
				lmsc_pkg::SEL_LAST_RUN: load_next = 32'($signed(avg_i_last_reg));
				lmsc_pkg::SEL_PRESENT_RUN: begin
					load_next = (run_reg == lmsc_pkg::RUN_LONG) ? run_avg_i
						: 32'($signed(avg_i_last_reg));
				end
				lmsc_pkg::SEL_AVERAGED: load_next = 32'(MEAS_I.current_ma);
				lmsc_pkg::SEL_FILTERED: load_next = filt_i;
				lmsc_pkg::SEL_DESIGN_DIV5: begin
					load_next = -32'($signed({16'h0000, design_cap_reg}) / lmsc_pkg::DESIGN_DIVISOR);
				end
				lmsc_pkg::SEL_USER_RATE: load_next = -$signed({16'h0000, user_ma_reg});
				default: load_next = LOAD_VALUE_O;
			endcase
		end else begin
			case (active_sel_reg)
				lmsc_pkg::SEL_LAST_RUN: load_next = 32'($signed(avg_p_last_reg));
				lmsc_pkg::SEL_PRESENT_RUN: begin
					load_next = (run_reg == lmsc_pkg::RUN_LONG) ? run_avg_p
						: 32'($signed(avg_p_last_reg));
				end
				lmsc_pkg::SEL_AVERAGED: load_next = inst_p;
				lmsc_pkg::SEL_FILTERED: load_next = filt_p;
				lmsc_pkg::SEL_DESIGN_DIV5: begin
					load_next = -32'($signed({16'h0000, design_nrg_reg}) / lmsc_pkg::DESIGN_DIVISOR);
				end
				lmsc_pkg::SEL_USER_RATE: load_next = -$signed({16'h0000, user_mw_reg});
				default: load_next = LOAD_VALUE_O;
			endcase
		end
	end

	assign eod_next = term_v_reg + delta_v_reg;

	// Registered outputs
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			LOAD_VALUE_O <= 32'h00000000;
			LOAD_MODE_O <= lmsc_pkg::RST_LOAD_CFG[7];
			DESIGN_CAP_O <= lmsc_pkg::RST_DESIGN_CAP;
			DESIGN_NRG_O <= lmsc_pkg::RST_DESIGN_NRG;
			EOD_VOLTAGE_O <= lmsc_pkg::RST_TERM_V + lmsc_pkg::RST_DELTA_V;
			CHARGE_EMPTY_O <= 1'b0;
		end else begin
			LOAD_VALUE_O <= load_next;
			LOAD_MODE_O <= active_mode_reg;
			DESIGN_CAP_O <= design_cap_reg;
			DESIGN_NRG_O <= design_nrg_reg;
			EOD_VOLTAGE_O <= eod_next;
			CHARGE_EMPTY_O <= MEAS_I.voltage_mv <= eod_next;
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			RDATA_O <= 16'h0000;
		end else if (RD_I) begin
			case (ADDR_I)
				lmsc_pkg::OFS_LOAD_CFG: RDATA_O <= {8'h00, cfg_reg};
				lmsc_pkg::OFS_DESIGN_CAP: RDATA_O <= design_cap_reg;
				lmsc_pkg::OFS_DESIGN_NRG: RDATA_O <= design_nrg_reg;
				lmsc_pkg::OFS_TERM_V: RDATA_O <= term_v_reg;
				lmsc_pkg::OFS_USER_MA: RDATA_O <= user_ma_reg;
				lmsc_pkg::OFS_USER_MW: RDATA_O <= user_mw_reg;
				lmsc_pkg::OFS_AVG_I_LAST: RDATA_O <= avg_i_last_reg;
				lmsc_pkg::OFS_AVG_P_LAST: RDATA_O <= avg_p_last_reg;
				lmsc_pkg::OFS_DELTA_V: RDATA_O <= delta_v_reg;
				lmsc_pkg::OFS_STATUS: begin
					RDATA_O <= 16'h0000;
					RDATA_O[lmsc_pkg::ST_MODE_BIT] <= active_mode_reg;
					RDATA_O[lmsc_pkg::ST_LONG_BIT] <= run_reg == lmsc_pkg::RUN_LONG;
					RDATA_O[lmsc_pkg::ST_EMPTY_BIT] <= CHARGE_EMPTY_O;
				end
				lmsc_pkg::OFS_LOAD_LO: RDATA_O <= LOAD_VALUE_O[15:0];
				lmsc_pkg::OFS_LOAD_HI: RDATA_O <= LOAD_VALUE_O[31:16];
				lmsc_pkg::OFS_EOD_V: RDATA_O <= EOD_VOLTAGE_O;
				default: RDATA_O <= 16'h0000;
			endcase
		end else begin
			RDATA_O <= 16'h0000;
		end
	end
endmodule : lmsc_top
`default_nettype wire

// ---- lmsc_top_props.sv ----
/* Checker for the load model block: active model, load sources, parameters.
 * Assumes it is bound to lmsc_top and sees only its ports on one clock. */
`default_nettype none
module lmsc_top_props #(
	parameter int SEC_CYCLES = lmsc_pkg::SEC_CYCLES
) (
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire lmsc_pkg::lmsc_meas_t MEAS_I,
	input wire logic [15:0] RDATA_O,
	input wire logic signed [31:0] LOAD_VALUE_O,
	input wire logic LOAD_MODE_O,
	input wire logic [15:0] DESIGN_CAP_O,
	input wire logic [15:0] DESIGN_NRG_O,
	input wire logic [15:0] EOD_VOLTAGE_O,
	input wire logic CHARGE_EMPTY_O
);
	logic act_mode;
	logic [2:0] act_sel;
	logic [15:0] cap_exp;
	logic [15:0] nrg_exp;
	logic signed [31:0] pwr;
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);
	// Shadow of the active model; reserved codes never become active
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			act_mode <= 1'b1;
			act_sel <= lmsc_pkg::RST_SEL;
		end else if (WR_I && ADDR_I == lmsc_pkg::OFS_LOAD_CFG) begin
			act_mode <= WDATA_I[7];
			if (WDATA_I[2:0] != lmsc_pkg::SEL_RSVD_A && WDATA_I[2:0] != lmsc_pkg::SEL_RSVD_B) begin
				act_sel <= WDATA_I[2:0];
			end
		end
	end
	// Expected parameters after clamping
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cap_exp <= lmsc_pkg::RST_DESIGN_CAP;
			nrg_exp <= lmsc_pkg::RST_DESIGN_NRG;
		end else if (WR_I && ADDR_I == lmsc_pkg::OFS_DESIGN_CAP) begin
			cap_exp <= (WDATA_I > lmsc_pkg::MAX_DESIGN_CAP) ? lmsc_pkg::MAX_DESIGN_CAP : WDATA_I;
		end else if (WR_I && ADDR_I == lmsc_pkg::OFS_DESIGN_NRG) begin
			nrg_exp <= (WDATA_I > lmsc_pkg::MAX_DESIGN_NRG) ? lmsc_pkg::MAX_DESIGN_NRG : WDATA_I;
		end
	end
	// Power of the present sample, truncated toward zero
	always_ff @(posedge SYS_CLK_I) begin
		pwr <= (32'(MEAS_I.current_ma) * $signed(32'(MEAS_I.voltage_mv))) / 32'sh000003E8;
	end
	AST_MODE: assert property (LOAD_MODE_O == $past(act_mode))
		else $error("model output differs from configured mode");
	AST_SEL2_CUR: assert property (!$past(act_mode) && $past(act_sel) == lmsc_pkg::SEL_AVERAGED
		|-> LOAD_VALUE_O == 32'($signed($past(MEAS_I.current_ma))))
		else $error("averaged current source wrong");
	AST_SEL2_PWR: assert property ($past(act_mode) && $past(act_sel) == lmsc_pkg::SEL_AVERAGED |-> LOAD_VALUE_O == pwr)
		else $error("averaged power source wrong");
	AST_SEL4_CUR: assert property (!$past(act_mode) && $past(act_sel) == lmsc_pkg::SEL_DESIGN_DIV5
		|-> LOAD_VALUE_O == -$signed({16'h0000, $past(cap_exp)} / 32'h00000005))
		else $error("capacity over five source wrong");
	AST_SEL4_PWR: assert property ($past(act_mode) && $past(act_sel) == lmsc_pkg::SEL_DESIGN_DIV5
		|-> LOAD_VALUE_O == -$signed({16'h0000, $past(nrg_exp)} / 32'h00000005))
		else $error("energy over five source wrong");
	AST_CAP: assert property (!WR_I && !$past(WR_I) |-> DESIGN_CAP_O == cap_exp)
		else $error("capacity parameter wrong");
	AST_NRG: assert property (!WR_I && !$past(WR_I) |-> DESIGN_NRG_O == nrg_exp)
		else $error("energy parameter wrong");
	AST_STATUS: assert property (RD_I && ADDR_I == lmsc_pkg::OFS_STATUS |=> RDATA_O[0] == LOAD_MODE_O)
		else $error("status model bit differs from active model");
	AST_EMPTY: assert property ($stable(EOD_VOLTAGE_O) && $stable(MEAS_I.voltage_mv)
		|-> CHARGE_EMPTY_O == (MEAS_I.voltage_mv <= EOD_VOLTAGE_O))
		else $error("empty flag wrong");
endmodule : lmsc_top_props
bind lmsc_top lmsc_top_props #(.SEC_CYCLES(SEC_CYCLES)) u_props (.*);
`default_nettype wire

// ---- lmsc_host.sv ----
/* Host model: register master of the load model block.
 * Assumes one clock shared with the block and a slave that never stalls. */
`default_nettype none
module lmsc_host (
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	output logic [7:0] addr_o,
	output logic [15:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		addr_o = 8'h00;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// One-cycle write; released lines show the inverse, not stale data
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] v;
		v = (a == lmsc_pkg::OFS_LOAD_CFG) ? (d & 16'h0087) : d;
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= v;
		wr_o <= 1'b1;
		@(posedge clk_i);
		addr_o <= ~a;
		wdata_o <= ~v;
		wr_o <= 1'b0;
	endtask : wr
	// One-cycle read; data taken at the edge closing the answer cycle
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		addr_o <= ~a;
		rd_o <= 1'b0;
		@(posedge clk_i);
		d = rdata_i;
	endtask : rd
endmodule : lmsc_host
`default_nettype wire

// ---- tb.sv ----
/* Bench of the load model block: defaults, clamps, empty point, all sources but the filtered one.
 * Assumes SEC_CYCLES of 10 so a 500 tick run stays short. */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] RA [7] = '{8'h05, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h7F};
	localparam logic [15:0] RV [7] = '{16'h0081, 16'h053C, 16'h1360, 16'h0C80, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [7:0] CA [5] = '{8'h06, 8'h06, 8'h08, 8'h0A, 8'h0A};
	localparam logic [15:0] CW [5] = '{16'hFFFF, 16'h1F40, 16'h8000, 16'h09C3, 16'h0E75};
	localparam logic [15:0] CE [5] = '{16'h1F40, 16'h1F40, 16'h7FFF, 16'h09C4, 16'h0E74};
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic dsg = 1'b0;
	logic spk = 1'b0;
	logic [15:0] spk_mv = 16'h0000;
	lmsc_pkg::lmsc_meas_t meas = 32'h00000E74;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic wr;
	logic rd;
	logic signed [31:0] load;
	logic [15:0] eod;
	logic empty;
	int errors = 0;
	int n_checks = 0;
	always #5 sys_clk = ~sys_clk;
	lmsc_host host (.clk_i(sys_clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	lmsc_top #(.SEC_CYCLES(10)) DUT (.SYS_CLK_I(sys_clk), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .MEAS_I(meas), .DSG_ACTIVE_I(dsg), .SPIKE_VALID_I(spk), .SPIKE_MV_I(spk_mv),
		.RDATA_O(rdata), .LOAD_VALUE_O(load), .LOAD_MODE_O(), .DESIGN_CAP_O(), .DESIGN_NRG_O(),
		.EOD_VOLTAGE_O(eod), .CHARGE_EMPTY_O(empty));
	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk16
	task automatic chk32(input string nm, input logic signed [31:0] e, input logic signed [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk32
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	// Sources 4 and 6 come out negated, as discharge is negative
	function automatic logic signed [31:0] exp_load(input logic md, input logic [2:0] s,
		input lmsc_pkg::lmsc_meas_t m, input logic [15:0] cap, input logic [15:0] nrg, input logic [15:0] um,
		input logic [15:0] uw);
		case (s)
			3'h2: return md ? (32'(m.current_ma) * $signed(32'(m.voltage_mv))) / 32'sh000003E8 : 32'(m.current_ma);
			3'h4: return -$signed({16'h0000, md ? nrg : cap} / 32'h00000005);
			3'h6: return -$signed({16'h0000, md ? uw : um});
			default: return 32'shFFFFFFCE;
		endcase
	endfunction : exp_load
	task automatic do_reset();
		@(posedge sys_clk) resetn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
	endtask : do_reset
	task automatic check_defaults();
		logic [15:0] d;
		for (int i = 0; i < 7; i++) begin
			host.rd(RA[i], d);
			chk16("reset_reg", RV[i], d);
		end
		chk32("reset_load", 32'shFFFFFFCE, load);
		chk16("reset_eod", 16'h0C81, eod);
		$display("test defaults done");
	endtask : check_defaults
	task automatic clamp_and_empty();
		logic [15:0] d;
		for (int i = 0; i < 5; i++) begin
			host.wr(CA[i], CW[i]);
			host.rd(CA[i], d);
			chk16("clamp", CE[i], d);
		end
		host.wr(lmsc_pkg::OFS_TERM_V, 16'h0BB8);
		host.wr(lmsc_pkg::OFS_DELTA_V, 16'h0032);
		@(posedge sys_clk) meas.voltage_mv <= 16'h0BEA;
		repeat (3) @(posedge sys_clk);
		chk16("eod", 16'h0BEA, eod);
		chk16("empty_at", 16'h0001, {15'h0000, empty});
		meas.voltage_mv <= 16'h0BEB;
		repeat (3) @(posedge sys_clk);
		chk16("empty_above", 16'h0000, {15'h0000, empty});
		// Learned margin of 80 mV moves the empty point to 3080 mV
		spk <= 1'b1;
		spk_mv <= 16'h0050;
		@(posedge sys_clk) spk <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk16("eod_learn", 16'h0C08, eod);
		chk16("empty_learn", 16'h0001, {15'h0000, empty});
		host.rd(lmsc_pkg::OFS_STATUS, d);
		chk16("status_empty", 16'h0005, d);
		meas.voltage_mv <= 16'h0E74;
		$display("test clamp_and_empty done");
	endtask : clamp_and_empty
	task automatic sel_sweep();
		logic [15:0] d;
		logic [15:0] p [4];
		logic [2:0] eff;
		for (int i = 0; i < 4; i++) begin
			p[i] = 16'($urandom_range(i == 0 ? 8000 : 32767));
			host.wr(8'(6 + 2 * i + (i > 1 ? 2 : 0)), p[i]);
		end
		for (int md = 0; md < 2; md++) begin
			for (int s = 0; s < 8; s++) begin
				if (s != 5 && s != 7) eff = 3'(s);
				meas <= {-$signed(16'($urandom_range(3000))), 16'($urandom_range(4500, 2500))};
				host.wr(lmsc_pkg::OFS_LOAD_CFG, {8'h00, 1'(md), 4'($urandom), 3'(s)});
				repeat (3) @(posedge sys_clk);
				if (s != 3) chk32("load", exp_load(1'(md), eff, meas, p[0], p[1], p[2], p[3]), load);
				host.rd(lmsc_pkg::OFS_LOAD_CFG, d);
				chk16("cfg", {8'h00, 1'(md), 4'h0, 3'(s)}, d);
			end
		end
		$display("test sel_sweep done");
	endtask : sel_sweep
	task automatic run_test();
		logic [15:0] d;
		meas <= {16'hFF38, 16'h0E10};
		dsg <= 1'b1;
		host.wr(lmsc_pkg::OFS_LOAD_CFG, 16'h0001);
		repeat (4900) @(posedge sys_clk);
		chk32("early", 32'shFFFFFFCE, load);
		repeat (300) @(posedge sys_clk);
		chk32("running", 32'shFFFFFF38, load);
		host.rd(lmsc_pkg::OFS_STATUS, d);
		chk16("status_long", 16'h0002, d);
		dsg <= 1'b0;
		host.rd(lmsc_pkg::OFS_AVG_I_LAST, d);
		chk16("i_last", 16'hFF38, d);
		host.rd(lmsc_pkg::OFS_AVG_P_LAST, d);
		chk16("p_last", 16'hFD30, d);
		host.wr(lmsc_pkg::OFS_LOAD_CFG, 16'h0080);
		repeat (3) @(posedge sys_clk);
		chk32("p_last_load", 32'shFFFFFD30, load);
		host.rd(lmsc_pkg::OFS_LOAD_LO, d);
		chk16("load_lo", 16'hFD30, d);
		host.rd(lmsc_pkg::OFS_LOAD_HI, d);
		chk16("load_hi", 16'hFFFF, d);
		$display("test run done");
	endtask : run_test
	// Main sequence, ending with a reset and a second defaults check after the run has ended
	initial begin
		void'($urandom(94));
		do_reset();
		check_defaults();
		clamp_and_empty();
		sel_sweep();
		run_test();
		do_reset();
		check_defaults();
		close_out();
	end
	// Watchdog: the tests need about 5500 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		close_out();
	end
endmodule : tb
`default_nettype wire
